// ==== rtl/tcc_pkg.sv ====
// Package of constants, types and register map for the 8-bit timer compare core
// How it works
// - Tick source: I/O clock, crystal when selected
// - Clock select zero stops and holds counter
// - Counter readable and writable at any time
// - Counter write beats clear or count
// - Tick clears, increments or decrements; top/bottom flags
// - Three-bit mode field split over controls A/B
// - Overflow flag set per mode
// - Each channel compares counter every cycle
// - Match sets channel flag on next tick
// - Flag clears on service or written one
// - PWM modes buffer compare values; others direct
// - Buffer copies to active at top/bottom
// - CPU access targets buffer when buffering
// - Force strobe acts like match outside PWM modes, no flag
// - Counter write blocks next tick's match
// - Output register kept across mode change
// - Output mode bits unbuffered, act next match
// - Nonzero output mode overrides port data bit; direction bit still drives enable
// - Output mode zero leaves output register
// - Output state register separate from pin
// - Bottom indication when counter becomes zero
// - Max indication when counter becomes 255
// - Mode zero counts up, overflow at wrap
package tcc_pkg;

  // --------------------------------------------------------------------------
  // Register map (consecutive word addresses)
  // --------------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL_A  = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B  = 4'h1;
  localparam logic [3:0] ADDR_COUNT   = 4'h2;
  localparam logic [3:0] ADDR_CMP_A   = 4'h3;
  localparam logic [3:0] ADDR_CMP_B   = 4'h4;
  localparam logic [3:0] ADDR_FLAGS   = 4'h5;
  localparam logic [3:0] ADDR_INT_EN  = 4'h6;
  localparam logic [3:0] ADDR_ASYNC   = 4'h7;
  localparam logic [3:0] ADDR_PORT    = 4'h8;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int CA_MODE_LO   = 0;
  localparam int CA_COM_B_LO  = 4;
  localparam int CA_COM_A_LO  = 6;
  localparam int CB_CS_LO     = 0;
  localparam int CB_MODE_HI   = 3;
  localparam int CB_FORCE_B   = 6;
  localparam int CB_FORCE_A   = 7;
  localparam int FL_OVF       = 0;
  localparam int FL_CMP_A     = 1;
  localparam int FL_CMP_B     = 2;
  localparam int AS_SEL       = 5;
  localparam int PT_DATA_A    = 0;
  localparam int PT_DATA_B    = 1;
  localparam int PT_DIR_A     = 2;
  localparam int PT_DIR_B     = 3;

  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [1:0] COM_NONE   = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  // Waveform mode codes
  localparam logic [2:0] WM_NORMAL   = 3'h0;
  localparam logic [2:0] WM_PC_MAX   = 3'h1;
  localparam logic [2:0] WM_CTC      = 3'h2;
  localparam logic [2:0] WM_FAST_MAX = 3'h3;
  localparam logic [2:0] WM_PC_OCR   = 3'h5;
  localparam logic [2:0] WM_FAST_OCR = 3'h7;

  typedef enum logic {TCC_UP, TCC_DOWN} tcc_dir_e;

  typedef struct packed {
    logic [7:0] act;
    logic [7:0] buf_v;
    logic       out;
  } tcc_chan_s;

endpackage : tcc_pkg

// ==== rtl/tcc_core.sv ====
// Timer/counter core with two compare channels and Avalon-MM registers
module tcc_core
  import tcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        tick_io,
  input  wire logic        tick_crystal,
  input  wire logic        port_in_a,
  input  wire logic        port_in_b,
  output logic             pin_out_a,
  output logic             pin_oe_n_a,
  output logic             pin_out_b,
  output logic             pin_oe_n_b,
  output logic             async_clock_select,
  output logic             overflow_flag,
  output logic             compare_flag_a,
  output logic             compare_flag_b,
  output logic             irq,
  input  wire logic        irq_ack_ovf,
  input  wire logic        irq_ack_a,
  input  wire logic        irq_ack_b
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [7:0]  timer_control_a;
  logic [7:0]  timer_control_b;
  logic [7:0]  count_value;
  logic [2:0]  int_en;
  logic [3:0]  port_reg;
  logic        block_reg;
  tcc_dir_e    dir_reg;
  tcc_chan_s   ch_a;
  tcc_chan_s   ch_b;
  logic        ack_reg;

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  wire         wr_en     = avs_write & ~ack_reg;
  wire         rd_en     = avs_read & ~ack_reg;
  wire         wr_ca     = wr_en & (avs_address == ADDR_CTRL_A);
  wire         wr_cb     = wr_en & (avs_address == ADDR_CTRL_B);
  wire         wr_cnt    = wr_en & (avs_address == ADDR_COUNT);
  wire         wr_ocra   = wr_en & (avs_address == ADDR_CMP_A);
  wire         wr_ocrb   = wr_en & (avs_address == ADDR_CMP_B);
  wire         wr_flags  = wr_en & (avs_address == ADDR_FLAGS);
  wire         wr_ie     = wr_en & (avs_address == ADDR_INT_EN);
  wire         wr_as     = wr_en & (avs_address == ADDR_ASYNC);
  wire         wr_port   = wr_en & (avs_address == ADDR_PORT);
  wire [7:0]   wbyte     = avs_writedata[7:0];

  wire [2:0]   waveform_mode_field = {timer_control_b[CB_MODE_HI],
                                      timer_control_a[CA_MODE_LO+1:CA_MODE_LO]};
  wire [2:0]   clock_select_field  = timer_control_b[CB_CS_LO+2:CB_CS_LO];
  wire [1:0]   com_a     = timer_control_a[CA_COM_A_LO+1:CA_COM_A_LO];
  wire [1:0]   com_b     = timer_control_a[CA_COM_B_LO+1:CA_COM_B_LO];

  wire         is_pwm    = (waveform_mode_field != WM_NORMAL) && (waveform_mode_field != WM_CTC);
  wire         is_pc     = (waveform_mode_field == WM_PC_MAX) || (waveform_mode_field == WM_PC_OCR);
  wire         top_ocr   = (waveform_mode_field == WM_CTC) || (waveform_mode_field == WM_PC_OCR)
                           || (waveform_mode_field == WM_FAST_OCR);
  wire [7:0]   top_val   = top_ocr ? ch_a.act : CNT_MAX;

  // tick enable from external prescaler, source chosen by select bit
  logic        async_sel_reg;
  wire         timer_tick = (clock_select_field != CS_STOP) &
                            (async_sel_reg ? tick_crystal : tick_io);

  wire         at_top    = (count_value == top_val);
  wire         at_bottom = (count_value == CNT_BOTTOM);
  wire         at_max    = (count_value == CNT_MAX);

  // --------------------------------------------------------------------------
  // Counter next value
  // --------------------------------------------------------------------------
  logic [7:0]  cnt_next;
  tcc_dir_e    dir_next;
  logic        ovf_evt;
  logic        reload_evt;
  always_comb
  begin
    cnt_next   = count_value;
    dir_next   = dir_reg;
    ovf_evt    = 1'b0;
    reload_evt = 1'b0;
    if (timer_tick)
    begin
      if (is_pc)
      begin
        if (dir_reg == TCC_UP)
        begin
          if (at_top)
          begin
            dir_next   = TCC_DOWN;
            cnt_next   = count_value - 8'h01;
            reload_evt = 1'b1;
          end
          else
            cnt_next = count_value + 8'h01;
        end
        else
        begin
          if (at_bottom)
          begin
            dir_next = TCC_UP;
            cnt_next = count_value + 8'h01;
            ovf_evt  = 1'b1;
          end
          else
            cnt_next = count_value - 8'h01;
        end
      end
      else
      begin
        dir_next = TCC_UP;
        if (at_top && waveform_mode_field != WM_NORMAL)
        begin
          cnt_next   = CNT_BOTTOM;
          reload_evt = 1'b1;
          ovf_evt    = (waveform_mode_field != WM_CTC);
        end
        else
          cnt_next = count_value + 8'h01;
        if (at_max && !(waveform_mode_field == WM_FAST_OCR || waveform_mode_field == WM_FAST_MAX))
          ovf_evt = 1'b1;
      end
    end
    if (wr_cnt)
      cnt_next = wbyte;
  end

  // continuous comparison, gated off one tick after a counter write
  wire         match_a   = (count_value == ch_a.act);
  wire         match_b   = (count_value == ch_b.act);
  wire         hit_a     = timer_tick & match_a & ~block_reg;
  wire         hit_b     = timer_tick & match_b & ~block_reg;
  wire         force_a   = wr_cb & wbyte[CB_FORCE_A] & ~is_pwm;
  wire         force_b   = wr_cb & wbyte[CB_FORCE_B] & ~is_pwm;

  // Output action per mode and output setting
  function automatic logic oc_act(input logic cur, input logic [1:0] com, input logic pwm,
                                  input logic pc, input tcc_dir_e dir);
    logic r;
    r = cur;
    if (com == COM_TOGGLE)
      r = pwm ? cur : ~cur;
    else if (com == COM_CLEAR)
      r = (pc && dir == TCC_DOWN) ? 1'b1 : 1'b0;
    else if (com == COM_SET)
      r = (pc && dir == TCC_DOWN) ? 1'b0 : 1'b1;
    return r;
  endfunction : oc_act

  wire         fast_bot  = timer_tick & ~is_pc & is_pwm & at_top;
  function automatic logic oc_next(input tcc_chan_s ch, input logic hit, input logic frc,
                                   input logic [1:0] com);
    logic r;
    r = ch.out;
    if (fast_bot && com == COM_CLEAR)
      r = 1'b1;
    else if (fast_bot && com == COM_SET)
      r = 1'b0;
    if (hit | frc)
      r = oc_act(ch.out, com, is_pwm, is_pc, dir_reg);
    return r;
  endfunction : oc_next

  wire         oc_a_next = oc_next(ch_a, hit_a, force_a, com_a);
  wire         oc_b_next = oc_next(ch_b, hit_b, force_b, com_b);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_control_a <= RESET_BYTE;
      timer_control_b <= RESET_BYTE;
      count_value     <= RESET_BYTE;
      dir_reg         <= TCC_UP;
      block_reg       <= 1'b0;
      int_en          <= 3'h0;
      port_reg        <= 4'h0;
      async_sel_reg   <= 1'b0;
      ch_a            <= '0;
      ch_b            <= '0;
    end
    else
    begin
      if (wr_ca)
        timer_control_a <= wbyte;
      if (wr_cb)
        timer_control_b <= wbyte & 8'h3f;
      if (wr_ie)
        int_en <= wbyte[2:0];
      if (wr_port)
        port_reg <= wbyte[3:0];
      if (wr_as)
        async_sel_reg <= wbyte[AS_SEL];
      count_value <= cnt_next;
      dir_reg     <= dir_next;
      if (wr_cnt)
        block_reg <= 1'b1;
      else if (timer_tick)
        block_reg <= 1'b0;
      ch_a.out <= oc_a_next;
      ch_b.out <= oc_b_next;
      if (wr_ocra)
        ch_a.buf_v <= wbyte;
      if (wr_ocrb)
        ch_b.buf_v <= wbyte;
      if (wr_ocra && !is_pwm)
        ch_a.act <= wbyte;
      else if (is_pwm && (reload_evt || (timer_tick && is_pc && at_bottom)))
        ch_a.act <= ch_a.buf_v;
      if (wr_ocrb && !is_pwm)
        ch_b.act <= wbyte;
      else if (is_pwm && (reload_evt || (timer_tick && is_pc && at_bottom)))
        ch_b.act <= ch_b.buf_v;
    end
  end

  // --------------------------------------------------------------------------
  // Flags: set wins over clear
  // --------------------------------------------------------------------------
  wire [2:0]   flag_set  = {hit_b, hit_a, ovf_evt};
  wire [2:0]   flag_clr  = (wr_flags ? wbyte[2:0] : 3'h0)
                           | {irq_ack_b, irq_ack_a, irq_ack_ovf};
  wire [2:0]   flag_cur  = {compare_flag_b, compare_flag_a, overflow_flag};
  wire [2:0]   flag_next = flag_set | (flag_cur & ~flag_clr);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overflow_flag   <= 1'b0;
      compare_flag_a  <= 1'b0;
      compare_flag_b  <= 1'b0;
      irq             <= 1'b0;
      pin_out_a       <= 1'b0;
      pin_out_b       <= 1'b0;
      pin_oe_n_a      <= 1'b1;
      pin_oe_n_b      <= 1'b1;
      async_clock_select <= 1'b0;
    end
    else
    begin
      overflow_flag   <= flag_next[FL_OVF];
      compare_flag_a  <= flag_next[FL_CMP_A];
      compare_flag_b  <= flag_next[FL_CMP_B];
      irq             <= |(flag_next & int_en);
      pin_out_a       <= (com_a != COM_NONE) ? oc_a_next : port_reg[PT_DATA_A];
      pin_out_b       <= (com_b != COM_NONE) ? oc_b_next : port_reg[PT_DATA_B];
      pin_oe_n_a      <= ~port_reg[PT_DIR_A];
      pin_oe_n_b      <= ~port_reg[PT_DIR_B];
      async_clock_select <= async_sel_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Bus read path: one wait cycle on every access
  // --------------------------------------------------------------------------
  logic [7:0]  rd_mux;
  always_comb
  begin
    unique case (avs_address)
      ADDR_CTRL_A: rd_mux = timer_control_a;
      ADDR_CTRL_B: rd_mux = timer_control_b;
      ADDR_COUNT:  rd_mux = count_value;
      ADDR_CMP_A:  rd_mux = is_pwm ? ch_a.buf_v : ch_a.act;
      ADDR_CMP_B:  rd_mux = is_pwm ? ch_b.buf_v : ch_b.act;
      ADDR_FLAGS:  rd_mux = {5'h00, flag_cur};
      ADDR_INT_EN: rd_mux = {5'h00, int_en};
      ADDR_ASYNC:  rd_mux = {2'h0, async_sel_reg, 5'h00};
      ADDR_PORT:   rd_mux = {2'h0, port_in_b, port_in_a, port_reg};
      default:     rd_mux = RESET_BYTE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_reg         <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else
    begin
      ack_reg         <= (avs_read | avs_write) & ~ack_reg;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_reg);
      if (rd_en)
        avs_readdata <= {24'h000000, rd_mux};
    end
  end

endmodule : tcc_core

// ==== sim/tcc_core_asserts.sv ====
// Concurrent checks on the timer compare core ports
module tcc_core_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        tick_io,
  input wire logic        tick_crystal,
  input wire logic        pin_out_a,
  input wire logic        async_clock_select,
  input wire logic        overflow_flag,
  input wire logic        compare_flag_a,
  input wire logic        compare_flag_b,
  input wire logic        irq,
  input wire logic        irq_ack_ovf,
  input wire logic        irq_ack_a
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire tick_any = tick_io | tick_crystal;
  wire flag_any = overflow_flag | compare_flag_a | compare_flag_b;
  wire req_ev   = avs_write | tick_any;

  AST_WAIT_ANSWER: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest not lowered after a request");
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_WAIT_CAUSE: assert property ($fell(avs_waitrequest) |-> $past(avs_read | avs_write))
    else $error("waitrequest fell without a request");
  AST_RD_UPPER: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_CMPA_TICK: assert property ($rose(compare_flag_a) |-> $past(tick_any))
    else $error("compare flag a set without a tick");
  AST_OVF_TICK: assert property ($rose(overflow_flag) |-> $past(tick_any))
    else $error("overflow flag set without a tick");
  AST_ACK_A: assert property (irq_ack_a && !tick_any |=> !compare_flag_a)
    else $error("compare flag a not cleared by service");
  AST_ACK_OVF: assert property (irq_ack_ovf && !tick_any |=> !overflow_flag)
    else $error("overflow flag not cleared by service");
  AST_IRQ_SRC: assert property (irq |-> flag_any || $past(flag_any))
    else $error("interrupt without a flag");
  AST_PIN_CAUSE: assert property ($changed(pin_out_a) |-> $past(req_ev) || $past(req_ev, 2))
    else $error("pin a changed without write or tick");
  AST_ASYNC_CAUSE: assert property ($changed(async_clock_select) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("source select changed without a write");
endmodule : tcc_core_asserts

bind tcc_core tcc_core_asserts u_tcc_core_asserts (
  .clk, .rst_n, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .tick_io, .tick_crystal,
  .pin_out_a, .async_clock_select, .overflow_flag, .compare_flag_a, .compare_flag_b, .irq,
  .irq_ack_ovf, .irq_ack_a
);

// ==== sim/testbench.sv ====
// Self-checking bench for the timer compare core
module testbench;
  import tcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Signals
  // ----------
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        tick_io = 1'b0, tick_crystal = 1'b0, port_in_a = 1'b0, port_in_b = 1'b0;
  logic        irq_ack_ovf = 1'b0, irq_ack_a = 1'b0, irq_ack_b = 1'b0;
  logic        pin_out_a, pin_oe_n_a, pin_out_b, pin_oe_n_b, async_clock_select;
  logic        overflow_flag, compare_flag_a, compare_flag_b, irq;
  int          err_count = 0;
  int          n_checks = 0;
  logic [7:0]  exp_q[$];
  logic [7:0]  lfsr = 8'h3e;

  tcc_core u_tcc_core (
    .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .tick_io, .tick_crystal, .port_in_a, .port_in_b, .pin_out_a,
    .pin_oe_n_a, .pin_out_b, .pin_oe_n_b, .async_clock_select, .overflow_flag,
    .compare_flag_a, .compare_flag_b, .irq, .irq_ack_ovf, .irq_ack_a, .irq_ack_b
  );

  always #25 clk = ~clk;
  // ----------
  // Tasks
  // ----------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    if (exp_q.size() != 0)
      err_count++;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic bus(input logic wr_en, input logic [3:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= wr_en;
    avs_read      <= !wr_en;
    do
    begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    check("wait cycles", 8'(n), 8'h02);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : rd

  task automatic ticks(input int k, input logic xtal);
    repeat (k)
    begin
      @(posedge clk);
      tick_io      <= !xtal;
      tick_crystal <= xtal;
      @(posedge clk);
      tick_io      <= 1'b0;
      tick_crystal <= 1'b0;
    end
  endtask : ticks

  task automatic pin(input logic o, input logic oe_n);
    repeat (3) @(posedge clk);
    check("pin_out_a", 8'(pin_out_a), 8'(o));
    check("pin_oe_n_a", 8'(pin_oe_n_a), 8'(oe_n));
  endtask : pin

  always @(posedge clk)
  begin
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      check("readdata", avs_readdata[7:0], exp_q.pop_front());
  end
  // ----------
  // Sequence
  // ----------
  initial
  begin
    #250000;
    err_count++;
    give_verdict();
  end

  initial
  begin
    logic [7:0] r;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 10; a++)
      rd(4'(a), 8'h00);
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00);
    lfsr = lfsr_next(lfsr);
    wr(ADDR_COUNT, lfsr);
    ticks(3, 1'b0);
    rd(ADDR_COUNT, lfsr);
    wr(ADDR_CTRL_B, 8'h01);
    fork
      ticks(1, 1'b0);
      wr(ADDR_COUNT, 8'h40);
    join
    rd(ADDR_COUNT, 8'h40);
    wr(ADDR_COUNT, 8'hfd);
    ticks(2, 1'b1);
    rd(ADDR_COUNT, 8'hfd);
    wr(ADDR_ASYNC, 8'h20);
    ticks(2, 1'b0);
    check("async_clock_select", 8'(async_clock_select), 8'h01);
    ticks(3, 1'b1);
    rd(ADDR_COUNT, 8'h00);
    rd(ADDR_FLAGS, 8'h01);
    check("overflow_flag", 8'(overflow_flag), 8'h01);
    wr(ADDR_ASYNC, 8'h00);
    @(posedge clk) irq_ack_ovf <= 1'b1;
    @(posedge clk) irq_ack_ovf <= 1'b0;
    check("async_clock_select", 8'(async_clock_select), 8'h00);
    rd(ADDR_FLAGS, 8'h00);
    lfsr = lfsr_next(lfsr);
    r = {1'b0, lfsr[6:0]} | 8'h02;
    wr(ADDR_CMP_A, r);
    wr(ADDR_INT_EN, 8'h02);
    wr(ADDR_COUNT, r);
    ticks(1, 1'b0);
    rd(ADDR_FLAGS, 8'h00);
    wr(ADDR_COUNT, r - 8'h01);
    ticks(2, 1'b0);
    rd(ADDR_FLAGS, 8'h02);
    check("irq", 8'(irq), 8'h01);
    check("compare_flag_a", 8'(compare_flag_a), 8'h01);
    wr(ADDR_FLAGS, 8'h02);
    rd(ADDR_FLAGS, 8'h00);
    check("irq", 8'(irq), 8'h00);
    wr(ADDR_CTRL_A, 8'h40);
    wr(ADDR_CTRL_B, 8'h81);
    pin(1'b1, 1'b1);
    wr(ADDR_PORT, 8'h04);
    pin(1'b1, 1'b0);
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_CTRL_B, 8'h81);
    pin(1'b0, 1'b0);
    wr(ADDR_CTRL_A, 8'h42);
    pin(1'b1, 1'b0);
    for (int i = 1; i < 4; i++)
    begin
      wr(ADDR_CTRL_A, {2'(i), 6'h02});
      wr(ADDR_CTRL_B, 8'h81);
      pin(1'(i == 3), 1'b0);
    end
    rd(ADDR_FLAGS, 8'h00);
    rd(ADDR_COUNT, r + 8'h01);
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_CMP_A, 8'h05);
    wr(ADDR_CTRL_A, 8'h03);
    wr(ADDR_COUNT, 8'h10);
    wr(ADDR_CMP_A, 8'h12);
    rd(ADDR_CMP_A, 8'h12);
    ticks(4, 1'b0);
    rd(ADDR_FLAGS, 8'h00);
    ticks(256, 1'b0);
    rd(ADDR_FLAGS, 8'h07);
    rd(ADDR_COUNT, 8'h14);
    @(posedge clk) irq_ack_a <= 1'b1;
    @(posedge clk) irq_ack_a <= 1'b0;
    rd(ADDR_FLAGS, 8'h05);
    check("compare_flag_b", 8'(compare_flag_b), 8'h01);
    check("compare_flag_a", 8'(compare_flag_a), 8'h00);
    wr(ADDR_PORT, 8'h0a);
    pin(1'b0, 1'b1);
    check("pin_out_b", 8'(pin_out_b), 8'h01);
    check("pin_oe_n_b", 8'(pin_oe_n_b), 8'h00);
    wr(ADDR_CTRL_A, 8'h13);
    pin(1'b0, 1'b1);
    check("pin_out_b", 8'(pin_out_b), 8'h00);
    @(posedge clk) {port_in_b, port_in_a} <= lfsr[1:0];
    rd(ADDR_PORT, {2'h0, lfsr[1:0], 4'ha});
    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_CTRL_A, 8'h41);
    wr(ADDR_CTRL_B, 8'h81);
    pin(1'b1, 1'b1);
    wr(ADDR_COUNT, 8'hfe);
    ticks(4, 1'b0);
    rd(ADDR_COUNT, 8'hfc);
    wr(ADDR_COUNT, 8'h02);
    ticks(3, 1'b0);
    rd(ADDR_COUNT, 8'h01);
    rd(ADDR_FLAGS, 8'h05);
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule : testbench
